// File: rtl/adcw_ctrl.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module adcw_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_trig,
  input  wire logic        cmp_hi,
  output logic [3:0]       chan_sel,
  output logic             sample_en,
  output logic [9:0]       dac_code,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]              converter_control_one;
    logic [7:0]              converter_control_two;
    logic [15:0][9:0]        data;
    logic [9:0]              up_a;
    logic [9:0]              lo_a;
    logic [9:0]              up_b;
    logic [9:0]              lo_b;
    logic [4:0]              status;
    logic [4:0]              mask;
    adcw_pkg::adcw_scan_st_t scan;
    logic [3:0]              chan;
    logic                    sar_start;
    logic                    wr_pend;
    logic [11:0]             wr_addr;
    logic [31:0]             rdata;
  } adcw_ctrl_t;

  adcw_ctrl_t cur_ff;
  adcw_ctrl_t nxt_ff;

  logic       tick;
  logic       sar_done;
  logic [9:0] sar_result;
  logic       sar_abort;
  logic       active;
  logic       addr_ok;
  logic [4:0] set_bits;
  logic [4:0] clr_bits;
  logic [3:0] ch_a;
  logic [3:0] ch_b;
  logic [9:0] wdata10;
  logic [3:0] start_ch;
  logic [3:0] watch_ch;
  logic       cont_mode;
  logic       trig_en;
  logic [2:0] pre_factor;
  logic       scan_busy;
  logic       chan_is_a;
  logic       chan_is_b;
  logic       chan_is_last;
  logic [1:0] flags_a;
  logic [1:0] flags_b;

  // ============================================================
  // Helpers

  // Window check, bit 1 upper crossing, bit 0 lower crossing
  function automatic logic [1:0] window_flags(input logic [9:0] v,
                                              input logic [9:0] up,
                                              input logic [9:0] lo);
    window_flags = {(v >= up), (v < lo)};
  endfunction

  // Word aligned byte address from the bus
  function automatic logic [11:0] word_addr(input logic [31:0] a);
    word_addr = {a[11:2], 2'b00};
  endfunction

  // Result registers fill the lowest sixteen words
  function automatic logic in_data_range(input logic [11:0] a);
    in_data_range = (a < adcw_pkg::DATA_BASE + 12'h040);
  endfunction

  // Register read mux
  // Data words sit at the bottom, control and thresholds above
  // Unmapped words read as zero
  function automatic logic [31:0] read_reg(input adcw_ctrl_t s, input logic [11:0] a);
    read_reg = 32'h0000_0000;
    if (in_data_range(a)) begin
      read_reg = {22'h000000, s.data[a[5:2]]};
    end else begin
      unique case (a)
        adcw_pkg::UP_A_ADDR:     read_reg = {22'h000000, s.up_a};
        adcw_pkg::LO_A_ADDR:     read_reg = {22'h000000, s.lo_a};
        adcw_pkg::UP_B_ADDR:     read_reg = {22'h000000, s.up_b};
        adcw_pkg::LO_B_ADDR:     read_reg = {22'h000000, s.lo_b};
        adcw_pkg::STAT_ADDR:     read_reg = {27'h0000000, s.status};
        adcw_pkg::MASK_ADDR:     read_reg = {27'h0000000, s.mask};
        adcw_pkg::CTRL_ONE_ADDR: read_reg = {24'h000000, s.converter_control_one};
        adcw_pkg::CTRL_TWO_ADDR: read_reg = {24'h000000, s.converter_control_two};
        default:                 read_reg = 32'h0000_0000;
      endcase
    end
  endfunction

  // ============================================================
  // Field decode

  // Control fields pulled out of the control registers
  assign start_ch = cur_ff.converter_control_one[adcw_pkg::CR1_SC_LSB +: 4];
  assign watch_ch = cur_ff.converter_control_one[adcw_pkg::CR1_CC_LSB +: 4];
  assign cont_mode = cur_ff.converter_control_two[adcw_pkg::CR2_CONT_BIT];
  assign trig_en = cur_ff.converter_control_two[adcw_pkg::CR2_TRIG_BIT];
  assign pre_factor = cur_ff.converter_control_two[adcw_pkg::CR2_PR_LSB +: 3];
  assign scan_busy = (cur_ff.scan == adcw_pkg::ADCW_SCAN_BUSY);

  // Watched pair, B wraps from 15 to 0
  assign ch_a = watch_ch;
  assign ch_b = watch_ch + 4'h1;
  assign chan_is_a = (cur_ff.chan == ch_a);
  assign chan_is_b = (cur_ff.chan == ch_b);
  assign chan_is_last = (cur_ff.chan == adcw_pkg::LAST_CH);

  // Window checks on the fresh result
  assign flags_a = window_flags(sar_result, cur_ff.up_a, cur_ff.lo_a);
  assign flags_b = window_flags(sar_result, cur_ff.up_b, cur_ff.lo_b);

  // ============================================================
  // Submodules

  adcw_prescaler u_pre (
    .ref_clk         (ref_clk),
    .rstn            (rstn),
    .run             (scan_busy),
    .prescale_factor (pre_factor),
    .tick            (tick)
  );

  adcw_sar u_sar (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .start     (cur_ff.sar_start),
    .abort     (sar_abort),
    .tick      (tick),
    .cmp_hi    (cmp_hi),
    .sample_en (sample_en),
    .dac_code  (dac_code),
    .done      (sar_done),
    .result    (sar_result)
  );

  // ============================================================
  // Next state

  // Decode, scan sequencing, watchdogs and status
  always_comb begin
    // Defaults for this cycle
    nxt_ff = cur_ff;
    nxt_ff.sar_start = 1'b0;
    set_bits = 5'h00;
    clr_bits = 5'h00;
    sar_abort = 1'b0;
    wdata10 = hwdata[9:0];
    // Conversion active flag as software sees it
    active = cur_ff.converter_control_two[adcw_pkg::CR2_ACT_BIT];
    // Bus address phase accepted this cycle
    addr_ok = hsel && hready && ((htrans == adcw_pkg::HTRANS_NONSEQ) ||
                                 (htrans == adcw_pkg::HTRANS_SEQ));

    // Data phase of a write
    if (cur_ff.wr_pend) begin
      unique case (cur_ff.wr_addr)
        adcw_pkg::UP_A_ADDR:     nxt_ff.up_a = wdata10;
        adcw_pkg::LO_A_ADDR:     nxt_ff.lo_a = wdata10;
        adcw_pkg::UP_B_ADDR:     nxt_ff.up_b = wdata10;
        adcw_pkg::LO_B_ADDR:     nxt_ff.lo_b = wdata10;
        adcw_pkg::STAT_ADDR:     clr_bits = hwdata[4:0];
        adcw_pkg::MASK_ADDR:     nxt_ff.mask = hwdata[4:0];
        adcw_pkg::CTRL_ONE_ADDR: nxt_ff.converter_control_one = hwdata[7:0];
        adcw_pkg::CTRL_TWO_ADDR: nxt_ff.converter_control_two = hwdata[7:0];
        // Result words and holes ignore writes
        default:                 nxt_ff.mask = cur_ff.mask;
      endcase
    end

    // External trigger sets the active flag, ignored while already set
    if (ext_trig && trig_en && !active) begin
      nxt_ff.converter_control_two[adcw_pkg::CR2_ACT_BIT] = 1'b1;
    end

    // Scan sequencer
    unique case (cur_ff.scan)
      adcw_pkg::ADCW_SCAN_IDLE: begin
        if (active) begin
          nxt_ff.chan = start_ch;
          nxt_ff.sar_start = 1'b1;
          nxt_ff.scan = adcw_pkg::ADCW_SCAN_BUSY;
        end
      end
      adcw_pkg::ADCW_SCAN_BUSY: begin
        if (!active) begin
          sar_abort = 1'b1;
          nxt_ff.scan = adcw_pkg::ADCW_SCAN_IDLE;
        end else if (sar_done) begin
          nxt_ff.data[cur_ff.chan] = sar_result;
          if (chan_is_a) begin
            {set_bits[adcw_pkg::ST_A_UP], set_bits[adcw_pkg::ST_A_LO]} = flags_a;
          end
          if (chan_is_b) begin
            {set_bits[adcw_pkg::ST_B_UP], set_bits[adcw_pkg::ST_B_LO]} = flags_b;
          end
          if (chan_is_last) begin
            set_bits[adcw_pkg::ST_EOC] = 1'b1;
            if (cont_mode) begin
              nxt_ff.chan = start_ch;
              nxt_ff.sar_start = 1'b1;
            end else begin
              nxt_ff.converter_control_two[adcw_pkg::CR2_ACT_BIT] = 1'b0;
              nxt_ff.scan = adcw_pkg::ADCW_SCAN_IDLE;
            end
          end else begin
            nxt_ff.chan = cur_ff.chan + 4'h1;
            nxt_ff.sar_start = 1'b1;
          end
        end
      end
    endcase

    // Sticky status, set wins over clear
    nxt_ff.status = (cur_ff.status & ~clr_bits) | set_bits;

    // Address phase capture and registered read data
    nxt_ff.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      nxt_ff.wr_addr = word_addr(haddr);
      nxt_ff.rdata = hwrite ? 32'h0000_0000 : read_reg(cur_ff, word_addr(haddr));
    end
  end

  // ============================================================
  // State register

  // Reset values and update
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur_ff <= '0;
      // Control registers cleared, scan idle
      cur_ff.converter_control_one <= adcw_pkg::CTRL_RST;
      cur_ff.converter_control_two <= adcw_pkg::CTRL_RST;
      // Thresholds open the window to every result below 3ff
      cur_ff.up_a <= adcw_pkg::UP_RST;
      cur_ff.up_b <= adcw_pkg::UP_RST;
      cur_ff.lo_a <= adcw_pkg::LO_RST;
      cur_ff.lo_b <= adcw_pkg::LO_RST;
      cur_ff.scan <= adcw_pkg::ADCW_SCAN_IDLE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ============================================================
  // Outputs

  // Zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Read data from its register
  assign hrdata = cur_ff.rdata;
  assign chan_sel = cur_ff.chan;
  // Level interrupt from unmasked sticky bits
  assign irq = |(cur_ff.status & cur_ff.mask);

endmodule
`default_nettype wire

// File: rtl/adcw_pkg.sv
// ============================================================
// Shared constants for the autoscan converter control
package adcw_pkg;

  // Bus and converter sizes
  localparam int unsigned AW = 32;
  localparam int unsigned DW = 32;
  localparam int unsigned RES_W = 10;
  localparam int unsigned CH_W = 4;
  localparam int unsigned NUM_CH = 16;
  localparam logic [3:0] LAST_CH = 4'hf;

  // Printed register indexes, byte address is four times each
  localparam logic [11:0] CTRL_ONE_IDX = 12'h0fc;
  localparam logic [11:0] CTRL_TWO_IDX = 12'h0fd;
  localparam logic [11:0] CTRL_ONE_ADDR = 12'h3f0;
  localparam logic [11:0] CTRL_TWO_ADDR = 12'h3f4;

  // Further register byte addresses
  localparam logic [11:0] DATA_BASE = 12'h000;
  localparam logic [11:0] UP_A_ADDR = 12'h040;
  localparam logic [11:0] LO_A_ADDR = 12'h044;
  localparam logic [11:0] UP_B_ADDR = 12'h048;
  localparam logic [11:0] LO_B_ADDR = 12'h04c;
  localparam logic [11:0] STAT_ADDR = 12'h050;
  localparam logic [11:0] MASK_ADDR = 12'h054;

  // Control one fields
  localparam int unsigned CR1_SC_LSB = 4;
  localparam int unsigned CR1_CC_LSB = 0;
  // Control two fields
  localparam int unsigned CR2_PR_LSB = 5;
  localparam int unsigned CR2_CONT_BIT = 4;
  localparam int unsigned CR2_TRIG_BIT = 2;
  localparam int unsigned CR2_ACT_BIT = 0;

  // Status and mask bit positions
  localparam int unsigned ST_W = 5;
  localparam int unsigned ST_EOC = 0;
  localparam int unsigned ST_A_UP = 1;
  localparam int unsigned ST_A_LO = 2;
  localparam int unsigned ST_B_UP = 3;
  localparam int unsigned ST_B_LO = 4;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] UP_RST = 10'h3ff;
  localparam logic [9:0] LO_RST = 10'h000;

  // Conversion timing in prescaled ticks: 8 sample plus 10 x 2 trial = 28
  localparam logic [3:0] SAMPLE_TICKS = 4'h8;
  localparam logic [3:0] TRIAL_TICKS = 4'h2;

  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {
    ADCW_SAR_IDLE   = 2'b00,
    ADCW_SAR_SAMPLE = 2'b01,
    ADCW_SAR_TRIAL  = 2'b10
  } adcw_sar_st_t;

  typedef enum logic [0:0] {
    ADCW_SCAN_IDLE = 1'b0,
    ADCW_SCAN_BUSY = 1'b1
  } adcw_scan_st_t;

endpackage

// File: rtl/adcw_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Conversion clock tick generator
module adcw_prescaler (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [2:0] prescale_factor,
  output logic            tick
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } adcw_pre_t;

  adcw_pre_t cur_ff;
  adcw_pre_t nxt_ff;
  logic [2:0] last;

  // One tick every prescale_factor cycles, zero acts as one
  always_comb begin
    nxt_ff = cur_ff;
    last = (prescale_factor == 3'h0) ? 3'h0 : prescale_factor - 3'h1;
    nxt_ff.tick = 1'b0;
    if (!run) begin
      nxt_ff.cnt = 3'h0;
    end else if (cur_ff.cnt >= last) begin
      nxt_ff.cnt = 3'h0;
      nxt_ff.tick = 1'b1;
    end else begin
      nxt_ff.cnt = cur_ff.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign tick = cur_ff.tick;

endmodule
`default_nettype wire

// File: rtl/adcw_sar.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Successive approximation sequencer for one conversion
module adcw_sar (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       tick,
  input  wire logic       cmp_hi,
  output logic            sample_en,
  output logic [9:0]      dac_code,
  output logic            done,
  output logic [9:0]      result
);

  typedef struct packed {
    adcw_pkg::adcw_sar_st_t st;
    logic [3:0]             cnt;
    logic [3:0]             bitidx;
    logic [9:0]             code;
    logic [9:0]             result;
    logic                   done;
  } adcw_sar_t;

  adcw_sar_t cur_ff;
  adcw_sar_t nxt_ff;
  logic [9:0] kept;

  // Sample phase then one trial per bit, msb first
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    kept = cur_ff.code;
    if (!cmp_hi) begin
      kept[cur_ff.bitidx] = 1'b0;
    end
    unique case (cur_ff.st)
      adcw_pkg::ADCW_SAR_IDLE: begin
        if (start) begin
          nxt_ff.st = adcw_pkg::ADCW_SAR_SAMPLE;
          nxt_ff.cnt = 4'h0;
          nxt_ff.code = 10'h000;
        end
      end
      adcw_pkg::ADCW_SAR_SAMPLE: begin
        if (tick) begin
          if (cur_ff.cnt == adcw_pkg::SAMPLE_TICKS - 4'h1) begin
            nxt_ff.st = adcw_pkg::ADCW_SAR_TRIAL;
            nxt_ff.cnt = 4'h0;
            nxt_ff.bitidx = 4'h9;
            nxt_ff.code = 10'h200;
          end else begin
            nxt_ff.cnt = cur_ff.cnt + 4'h1;
          end
        end
      end
      adcw_pkg::ADCW_SAR_TRIAL: begin
        if (tick) begin
          if (cur_ff.cnt == adcw_pkg::TRIAL_TICKS - 4'h1) begin
            nxt_ff.cnt = 4'h0;
            if (cur_ff.bitidx == 4'h0) begin
              nxt_ff.st = adcw_pkg::ADCW_SAR_IDLE;
              nxt_ff.code = kept;
              nxt_ff.result = kept;
              nxt_ff.done = 1'b1;
            end else begin
              nxt_ff.bitidx = cur_ff.bitidx - 4'h1;
              nxt_ff.code = kept | (10'h001 << (cur_ff.bitidx - 4'h1));
            end
          end else begin
            nxt_ff.cnt = cur_ff.cnt + 4'h1;
          end
        end
      end
      default: nxt_ff.st = adcw_pkg::ADCW_SAR_IDLE;
    endcase
    if (abort) begin
      nxt_ff.st = adcw_pkg::ADCW_SAR_IDLE;
      nxt_ff.done = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign sample_en = (cur_ff.st == adcw_pkg::ADCW_SAR_SAMPLE);
  assign dac_code = cur_ff.code;
  assign done = cur_ff.done;
  assign result = cur_ff.result;

endmodule
`default_nettype wire

// File: tb/adcw_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Analog inputs and comparator at the far side
module adcw_analog_model (
  input  wire logic [159:0] levels,
  input  wire logic [3:0]   chan_sel,
  input  wire logic [9:0]   dac_code,
  output logic              cmp_hi
);
  // Ideal comparator on the selected input
  assign cmp_hi = (levels[chan_sel*10 +: 10] >= dac_code);
endmodule
`default_nettype wire

// File: tb/adcw_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checks for the converter control
module adcw_ctrl_sva (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0]  chan_sel,
  input wire logic        sample_en,
  input wire logic [9:0]  dac_code,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ============================================================
  // Bus answers
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_upper: assert property (hrdata[31:10] == 22'h000000)
    else $error("read data upper bits not zero");
  a_rdata_holds: assert property (!$past(hsel && hready && htrans[1]) |-> $stable(hrdata))
    else $error("read data moved without a request");

  // ============================================================
  // Converter timing and channel order
  a_sample_len: assert property ($rose(sample_en) |-> sample_en [*8])
    else $error("sampling shorter than eight cycles");
  a_trial_spacing: assert property ($changed(dac_code) && $past(dac_code) != 10'h000
      && dac_code != 10'h000 |=> $stable(dac_code))
    else $error("bit trial shorter than two cycles");
  a_msb_first: assert property ($fell(sample_en) |-> ##[0:1] dac_code == 10'h200)
    else $error("first trial is not the top bit");
  a_chan_hold: assert property (sample_en && $past(sample_en) |-> $stable(chan_sel))
    else $error("channel moved while sampling");
  a_scan_ascends: assert property ($changed(chan_sel)
      |-> chan_sel > $past(chan_sel) || $past(chan_sel) == 4'hf)
    else $error("channel order not ascending");

  // Main scenarios seen
  c_sample: cover property ($rose(sample_en));
  c_irq: cover property (irq);
  c_wrap: cover property ($changed(chan_sel) && $past(chan_sel) == 4'hf && chan_sel == 4'he);
endmodule

bind adcw_ctrl adcw_ctrl_sva chk_u (
  .ref_clk   (ref_clk),
  .rstn      (rstn),
  .hsel      (hsel),
  .htrans    (htrans),
  .hready    (hready),
  .hreadyout (hreadyout),
  .hresp     (hresp),
  .hrdata    (hrdata),
  .chan_sel  (chan_sel),
  .sample_en (sample_en),
  .dac_code  (dac_code),
  .irq       (irq)
);
`default_nettype wire

// File: tb/test_adc_autoscan_watchdog_control.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench for the converter control
module test_adc_autoscan_watchdog_control;
  logic         ref_clk;
  logic         rstn;
  logic         hsel;
  logic         hwrite;
  logic         ext_trig;
  logic         cmp_hi;
  logic         hreadyout;
  logic         hresp;
  logic         irq;
  logic         sample_en;
  logic [1:0]   htrans;
  logic [3:0]   chan_sel;
  logic [9:0]   dac_code;
  logic [31:0]  haddr;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic [31:0]  rd;
  logic [159:0] levels;
  int           mismatches;
  int           check_count;

  adcw_ctrl dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_trig(ext_trig),
    .cmp_hi(cmp_hi), .chan_sel(chan_sel), .sample_en(sample_en), .dac_code(dac_code),
    .irq(irq));

  adcw_analog_model model_u (
    .levels(levels), .chan_sel(chan_sel), .dac_code(dac_code), .cmp_hi(cmp_hi));

  // Clock at 200 MHz
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ============================================================
  // Helpers
  function automatic logic [9:0] lvl(input int ch);
    return 10'(ch * 60 + 7);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB transfer, called just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= adcw_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic waitc(input logic [3:0] v, output int n);
    n = 0;
    while (chan_sel !== v && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset;
    logic [11:0] a [8] = '{adcw_pkg::CTRL_ONE_ADDR, adcw_pkg::CTRL_TWO_ADDR,
      adcw_pkg::UP_A_ADDR, adcw_pkg::LO_A_ADDR, adcw_pkg::UP_B_ADDR,
      adcw_pkg::STAT_ADDR, adcw_pkg::MASK_ADDR, 12'h200};
    logic [31:0] e [8] = '{32'h0, 32'h0, 32'h3ff, 32'h0, 32'h3ff, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk(rd, e[i]);
    end
    bus(1'b1, adcw_pkg::DATA_BASE, 32'h155);
    @(posedge ref_clk);
    bus(1'b0, adcw_pkg::DATA_BASE, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_single;
    int n;
    bus(1'b1, adcw_pkg::UP_A_ADDR, 32'(lvl(14)));
    bus(1'b1, adcw_pkg::LO_A_ADDR, 32'(lvl(14)));
    bus(1'b1, adcw_pkg::UP_B_ADDR, 32'(lvl(15)) + 32'h1);
    bus(1'b1, adcw_pkg::LO_B_ADDR, 32'(lvl(15)) + 32'h1);
    bus(1'b1, adcw_pkg::MASK_ADDR, 32'h02);
    bus(1'b1, adcw_pkg::CTRL_ONE_ADDR, 32'hce); // Start 12, watch 14 and 15
    bus(1'b1, adcw_pkg::CTRL_TWO_ADDR, 32'h24); // Trigger enabled, single
    ext_trig <= 1'b1;
    @(posedge ref_clk);
    ext_trig <= 1'b0;
    waitc(4'hc, n);
    chk(32'(n < 1000), 32'h1);
    n = 0;
    do begin
      bus(1'b0, adcw_pkg::CTRL_TWO_ADDR, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    chk(rd, 32'h24);
    for (int ch = 11; ch < 16; ch++) begin
      bus(1'b0, 12'(4 * ch), 32'h0);
      chk(rd, (ch == 11) ? 32'h0 : 32'(lvl(ch)));
    end
    bus(1'b0, adcw_pkg::STAT_ADDR, 32'h0);
    chk(rd, 32'h13);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, adcw_pkg::STAT_ADDR, 32'h02);
    @(posedge ref_clk);
    bus(1'b0, adcw_pkg::STAT_ADDR, 32'h0);
    chk(rd, 32'h11);
    chk({31'h0, irq}, 32'h0);
    $display("test single done");
  endtask

  task automatic t_cont;
    int per [2];
    int n;
    bus(1'b1, adcw_pkg::CTRL_ONE_ADDR, 32'hee);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, adcw_pkg::CTRL_TWO_ADDR, k ? 32'h71 : 32'h31);
      waitc(4'he, n);
      waitc(4'hf, n);
      @(posedge ref_clk);
      waitc(4'he, per[k]);
      chk(32'(per[k] < 1000), 32'h1);
      bus(1'b0, adcw_pkg::CTRL_TWO_ADDR, 32'h0);
      chk(rd, k ? 32'h71 : 32'h31);
      n = 0;
      while (!(dac_code !== 10'h000 && sample_en === 1'b0) && n < 1000) begin
        @(posedge ref_clk);
        n++;
      end
      bus(1'b1, adcw_pkg::CTRL_TWO_ADDR, k ? 32'h70 : 32'h30);
      n = 0;
      repeat (120) begin
        @(posedge ref_clk);
        if (sample_en === 1'b1) n++;
      end
      chk(32'(n), 32'h0);
    end
    chk(32'((per[1] - per[0]) inside {[54:60]}), 32'h1);
    $display("test continuous done");
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    test_done();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    ext_trig = 1'b0;
    mismatches = 0;
    check_count = 0;
    for (int ch = 0; ch < 16; ch++) levels[ch*10 +: 10] = lvl(ch);
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_single();
    t_cont();
    test_done();
  end
endmodule
`default_nettype wire
